// [rtl/scf_serial_clock_format.sv]
module scf_serial_clock_format
  import scf_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             clkEn,
  input  wire scf_pkg::scf_cfg_t cfg,
  input  wire logic             serialClockIn,
  input  wire logic             timerMatchA,
  input  wire logic             timerMatchB,
  input  wire logic             rxCharDone,
  input  wire logic [8:0]       rxCharData,
  input  wire logic             txCharTaken,
  input  wire logic             txAllDone,
  input  wire logic             parityErrEvent,
  input  wire logic             framingErrEvent,
  input  wire logic             overrunErrEvent,
  input  wire logic             rxFifoAtLimit,
  input  wire logic             txFifoAtLimit,
  input  wire logic [8:0]       statusClear,
  input  wire logic             txWriteHigh,
  input  wire logic             txWriteLow,
  input  wire logic             txWriteCombined,
  input  wire logic [15:0]      txWriteData,
  output logic                  serialClockOut,
  output logic                  serialClockOe,
  output logic                  baseTick,
  output logic                  bitTick,
  output logic                  collisionTick,
  output logic                  collisionSelectBanned,
  output logic [3:0]            charBits,
  output scf_pkg::scf_status_t  status,
  output logic [7:0]            receiveHigh,
  output logic [7:0]            receiveLow,
  output logic [15:0]           receiveWordCombined,
  output logic [15:0]           transmitWordCombined
);

  scf_src_t    src;
  logic [7:0]  preCount;
  logic [7:0]  rateCount;
  logic [7:0]  modAcc;
  logic [4:0]  bitCount;
  logic        pinPrev;
  logic        timerPrev;
  logic        clockLevel;
  logic [8:0]  flags;
  logic [8:0]  rxWord;
  logic [8:0]  txWord;
  logic [7:0]  next_preCount;
  logic [7:0]  next_rateCount;
  logic [7:0]  next_modAcc;
  logic [4:0]  next_bitCount;
  logic        next_clockLevel;
  logic        next_baseTick;
  logic        next_bitTick;
  logic [8:0]  next_flags;
  logic [8:0]  next_rxWord;
  logic [8:0]  next_txWord;
  logic [7:0]  preLimit;
  logic [4:0]  perBit;
  logic        genTick;
  logic [8:0]  modSum;
  logic        pinRise;
  logic        timerRise;
  logic        timerAnd;
  logic [8:0]  setMask;
  logic [8:0]  modeMask;

  // ----------------------------------------------------------------
  // Clock source decode
  // ----------------------------------------------------------------
  always_comb begin
    if (cfg.syncMode) begin
      src = cfg.clockSelect[CKSEL_EXT_BIT] ? SRC_SYNC_EXT : SRC_SYNC_INT;
    end else if (cfg.clockSelect[CKSEL_EXT_BIT]) begin
      src = cfg.asyncClockSourceSelect ? SRC_ASYNC_TIMER : SRC_ASYNC_EXT_PIN;
    end else if (cfg.clockSelect == CKSEL_INT_OUT) begin
      src = SRC_ASYNC_INT_OUT;
    end else begin
      src = SRC_ASYNC_INT_HIZ;
    end
  end

  // ----------------------------------------------------------------
  // Baud rate generator
  // ----------------------------------------------------------------
  assign timerAnd  = timerMatchA & timerMatchB;
  assign pinRise   = serialClockIn & ~pinPrev;
  assign timerRise = timerAnd & ~timerPrev;
  assign modSum    = {1'b0, modAcc} + {1'b0, cfg.modulationDutySetting};

  always_comb begin
    // double speed halves the prescaler step
    preLimit = 8'((PRE_UNIT << {cfg.prescalerSelect, 1'b0}) >> cfg.doubleSpeedSelect);
    next_preCount  = preCount;
    next_rateCount = rateCount;
    next_modAcc    = modAcc;
    genTick        = 1'b0;
    if (preCount + 8'h01 >= preLimit) begin
      next_preCount = 8'h00;
      if (rateCount >= cfg.bitRateSetting) begin
        next_rateCount = 8'h00;
        if (cfg.rateModulationEnable) begin
          next_modAcc = modSum[7:0];
          genTick     = modSum[8];
        end else begin
          genTick = 1'b1;
        end
      end else begin
        next_rateCount = rateCount + 8'h01;
      end
    end else begin
      next_preCount = preCount + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Base and bit clocks, clock pin
  // ----------------------------------------------------------------
  always_comb begin
    next_baseTick = 1'b0;
    perBit        = BASE_PER_BIT;
    case (src)
      SRC_ASYNC_INT_HIZ, SRC_ASYNC_INT_OUT, SRC_SYNC_INT: next_baseTick = genTick;
      SRC_ASYNC_EXT_PIN: next_baseTick = pinRise;
      SRC_ASYNC_TIMER:   next_baseTick = timerRise;
      default:           next_baseTick = 1'b0;
    endcase
    if (cfg.syncMode) begin
      perBit = SYNC_PER_BIT;
    end else if (cfg.baseClockEighthSelect) begin
      perBit = BASE_PER_BIT_8;
    end
    next_bitCount   = bitCount;
    next_clockLevel = clockLevel;
    next_bitTick    = 1'b0;
    if (src == SRC_SYNC_EXT) begin
      // Sync external: each pin rise is one bit
      next_bitTick  = pinRise;
      next_bitCount = 5'h00;
    end else if (next_baseTick) begin
      if (bitCount + 5'h01 >= perBit) begin
        next_bitCount   = 5'h00;
        next_bitTick    = 1'b1;
        next_clockLevel = 1'b1;
      end else begin
        next_bitCount = bitCount + 5'h01;
        if (bitCount + 5'h01 == (perBit >> 1)) begin
          next_clockLevel = 1'b0;
        end
      end
    end
  end

  always_comb begin
    serialClockOe  = (src == SRC_ASYNC_INT_OUT) || (src == SRC_SYNC_INT);
    serialClockOut = clockLevel;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      preCount   <= 8'h00;
      rateCount  <= 8'h00;
      modAcc     <= 8'h00;
      bitCount   <= 5'h00;
      clockLevel <= 1'b1;
      pinPrev    <= 1'b0;
      timerPrev  <= 1'b0;
      baseTick   <= 1'b0;
      bitTick    <= 1'b0;
    end else if (clkEn) begin
      preCount   <= next_preCount;
      rateCount  <= next_rateCount;
      modAcc     <= next_modAcc;
      bitCount   <= next_bitCount;
      clockLevel <= next_clockLevel;
      pinPrev    <= serialClockIn;
      timerPrev  <= timerAnd;
      baseTick   <= next_baseTick;
      bitTick    <= next_bitTick;
    end
  end

  // ----------------------------------------------------------------
  // Collision detection clock
  // ----------------------------------------------------------------
  // divider from base clock
  scf_collision_divider u_collision (
    .clk           (clk),
    .arst_n        (arst_n),
    .clkEn         (clkEn),
    .baseTick      (next_baseTick),
    .dividerSelect (cfg.collisionClockDividerSelect),
    .reducedRange  (cfg.doubleSpeedSelect && (cfg.prescalerSelect == 2'h0)),
    .collisionTick (collisionTick),
    .selectBanned  (collisionSelectBanned)
  );

  // ----------------------------------------------------------------
  // Character length
  // ----------------------------------------------------------------
  always_comb begin
    // high/low pair, sync and smart card fixed at 8
    if (cfg.syncMode || cfg.smartCardSelect) begin
      charBits = CHAR_BITS_8;
    end else begin
      case ({cfg.charLengthHigh, cfg.charLengthLow})
        2'h2:    charBits = CHAR_BITS_8;
        2'h3:    charBits = CHAR_BITS_7;
        default: charBits = CHAR_BITS_9;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  always_comb begin
    setMask = '0;
    setMask[ST_RECEIVE_FULL]  = rxCharDone;
    setMask[ST_TRANSMIT_EMPT] = txCharTaken;
    setMask[ST_RECEIVE_READY] = rxCharDone;
    setMask[ST_TRANSMIT_DONE] = txAllDone;
    setMask[ST_PARITY_FAULT]  = parityErrEvent;
    setMask[ST_FRAMING_FAULT] = framingErrEvent;
    setMask[ST_OVERRUN_FAULT] = overrunErrEvent;
    setMask[ST_RX_FIFO_FULL]  = rxFifoAtLimit;
    setMask[ST_TX_FIFO_EMPTY] = txFifoAtLimit;
    // Set wins over a clear in the same cycle
    next_flags = (flags & ~statusClear) | setMask;
    if (cfg.smartCardSelect) begin
      modeMask = ST_SMART_MASK;
    end else if (cfg.fifoModeSelect) begin
      modeMask = ST_FIFO_MASK;
    end else begin
      modeMask = '0;
    end
  end

  assign status.flags = flags & modeMask;

  // ----------------------------------------------------------------
  // Data words
  // ----------------------------------------------------------------
  always_comb begin
    next_rxWord = rxCharDone ? rxCharData : rxWord;
    next_txWord = txWord;
    if (txWriteCombined) begin
      next_txWord = txWriteData[8:0];
    end else begin
      if (txWriteHigh) begin
        next_txWord[8] = txWriteData[8];
      end
      if (txWriteLow) begin
        next_txWord[7:0] = txWriteData[7:0];
      end
    end
  end

  assign receiveHigh          = {7'h00, rxWord[8]};
  assign receiveLow           = rxWord[7:0];
  assign receiveWordCombined  = {7'h00, rxWord};
  assign transmitWordCombined = {7'h00, txWord};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flags  <= ST_RESET;
      rxWord <= 9'h000;
      txWord <= {1'b1, TX_RESET};
    end else if (clkEn) begin
      flags  <= next_flags;
      rxWord <= next_rxWord;
      txWord <= next_txWord;
    end
  end

endmodule : scf_serial_clock_format

// [rtl/scf_pkg.sv]
package scf_pkg;

  // ----------------------------------------------------------------
  // Clock select codes
  // ----------------------------------------------------------------
  localparam logic [1:0] CKSEL_INT_HIZ = 2'h0;
  localparam logic [1:0] CKSEL_INT_OUT = 2'h1;
  localparam int         CKSEL_EXT_BIT = 1;

  // ----------------------------------------------------------------
  // Character length and rate figures
  // ----------------------------------------------------------------
  localparam logic [3:0] CHAR_BITS_9    = 4'h9;
  localparam logic [3:0] CHAR_BITS_8    = 4'h8;
  localparam logic [3:0] CHAR_BITS_7    = 4'h7;
  localparam logic [4:0] BASE_PER_BIT   = 5'h10;
  localparam logic [4:0] BASE_PER_BIT_8 = 5'h08;
  localparam logic [4:0] SYNC_PER_BIT   = 5'h02;
  localparam logic [7:0] PRE_UNIT       = 8'h02;
  localparam logic [7:0] DUTY_RESET     = 8'hFF;
  localparam logic [7:0] TX_RESET       = 8'hFF;

  // ----------------------------------------------------------------
  // Collision divider codes
  // ----------------------------------------------------------------
  localparam logic [1:0] COLL_DIV1   = 2'h0;
  localparam logic [1:0] COLL_DIV2   = 2'h1;
  localparam logic [1:0] COLL_DIV4   = 2'h2;
  localparam logic [1:0] COLL_BANNED = 2'h3;

  // ----------------------------------------------------------------
  // Status flag positions
  // ----------------------------------------------------------------
  localparam int ST_RECEIVE_FULL  = 0;
  localparam int ST_TRANSMIT_EMPT = 1;
  localparam int ST_RECEIVE_READY = 2;
  localparam int ST_TRANSMIT_DONE = 3;
  localparam int ST_PARITY_FAULT  = 4;
  localparam int ST_FRAMING_FAULT = 5;
  localparam int ST_OVERRUN_FAULT = 6;
  localparam int ST_RX_FIFO_FULL  = 7;
  localparam int ST_TX_FIFO_EMPTY = 8;
  localparam int ST_WIDTH         = 9;
  localparam logic [8:0] ST_RESET      = 9'h10A;
  localparam logic [8:0] ST_SMART_MASK = 9'h003;
  localparam logic [8:0] ST_FIFO_MASK  = 9'h1FC;

  typedef enum logic [2:0] {
    SRC_ASYNC_INT_HIZ,
    SRC_ASYNC_INT_OUT,
    SRC_ASYNC_EXT_PIN,
    SRC_ASYNC_TIMER,
    SRC_SYNC_INT,
    SRC_SYNC_EXT
  } scf_src_t;

  typedef struct packed {
    logic       syncMode;
    logic [1:0] clockSelect;
    logic       asyncClockSourceSelect;
    logic       baseClockEighthSelect;
    logic       doubleSpeedSelect;
    logic [1:0] prescalerSelect;
    logic [7:0] bitRateSetting;
    logic       rateModulationEnable;
    logic [7:0] modulationDutySetting;
    logic       charLengthHigh;
    logic       charLengthLow;
    logic [1:0] collisionClockDividerSelect;
    logic       smartCardSelect;
    logic       fifoModeSelect;
  } scf_cfg_t;

  typedef struct packed {
    logic [ST_WIDTH-1:0] flags;
  } scf_status_t;

endpackage : scf_pkg

// [rtl/scf_collision_divider.sv]
module scf_collision_divider
  import scf_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       clkEn,
  input  wire logic       baseTick,
  input  wire logic [1:0] dividerSelect,
  input  wire logic       reducedRange,
  output logic            collisionTick,
  output logic            selectBanned
);

  logic [1:0] count;
  logic [1:0] lastSelect;
  logic [1:0] next_count;
  logic       next_tick;
  logic [1:0] limit;

  // ----------------------------------------------------------------
  // Divide selection
  // ----------------------------------------------------------------
  always_comb begin
    limit        = 2'h0;
    selectBanned = 1'b0;
    if (reducedRange) begin
      case (dividerSelect)
        COLL_DIV1: limit = 2'h1;
        COLL_DIV2: limit = 2'h3;
        default:   selectBanned = 1'b1;
      endcase
    end else begin
      case (dividerSelect)
        COLL_DIV1: limit = 2'h0;
        COLL_DIV2: limit = 2'h1;
        COLL_DIV4: limit = 2'h3;
        default:   selectBanned = 1'b1;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_comb begin
    next_count = count;
    next_tick  = 1'b0;
    if (dividerSelect != lastSelect) begin
      next_count = 2'h0;
    end else if (baseTick && !selectBanned) begin
      if (count >= limit) begin
        next_count = 2'h0;
        next_tick  = 1'b1;
      end else begin
        next_count = count + 2'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count         <= 2'h0;
      lastSelect    <= COLL_DIV1;
      collisionTick <= 1'b0;
    end else if (clkEn) begin
      count         <= next_count;
      lastSelect    <= dividerSelect;
      collisionTick <= next_tick;
    end
  end

endmodule : scf_collision_divider

// [tb/scf_remote_dev.sv]
module scf_remote_dev (
  input  wire logic clk,
  input  wire logic run,
  output logic      serialClockIn
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Remote clock source
  // ----------------------------------------------------------------
  // base rate clock: one rise every two cycles, still when idle
  initial serialClockIn = 1'b0;
  always @(posedge clk) begin
    #1 serialClockIn <= run ? !serialClockIn : 1'b0;
  end
endmodule : scf_remote_dev

// [tb/scf_serial_clock_format_asserts.sv]
module scf_serial_clock_format_asserts
  import scf_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 arst_n,
  input wire logic                 clkEn,
  input wire scf_pkg::scf_cfg_t    cfg,
  input wire logic                 serialClockOe,
  input wire logic                 baseTick,
  input wire logic                 collisionTick,
  input wire logic                 collisionSelectBanned,
  input wire logic [3:0]           charBits,
  input wire scf_pkg::scf_status_t status,
  input wire logic [7:0]           receiveHigh,
  input wire logic [7:0]           receiveLow,
  input wire logic [15:0]          receiveWordCombined
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic asy;
  logic red;
  assign asy = !cfg.syncMode;
  assign red = cfg.doubleSpeedSelect && (cfg.prescalerSelect == 2'h0);
  AST_ASYNC_HIZ: assert property (asy && cfg.clockSelect == CKSEL_INT_HIZ |-> !serialClockOe)
    else $error("clock pin driven in async 00");
  AST_ASYNC_OUT: assert property (asy && cfg.clockSelect == CKSEL_INT_OUT |-> serialClockOe)
    else $error("clock pin not driven in async 01");
  AST_TIMER_HIZ: assert property (
    asy && cfg.clockSelect[1] && cfg.asyncClockSourceSelect |-> !serialClockOe)
    else $error("clock pin driven with timer source");
  AST_SYNC_PIN: assert property (
    cfg.syncMode |-> serialClockOe == !cfg.clockSelect[CKSEL_EXT_BIT])
    else $error("sync pin direction");
  AST_CHAR_LEN: assert property (
    asy && !cfg.smartCardSelect |-> charBits == (cfg.charLengthHigh
    ? (cfg.charLengthLow ? 4'h7 : 4'h8) : 4'h9)) else $error("character length");
  AST_COLL_BANNED: assert property (
    !red |-> collisionSelectBanned == (cfg.collisionClockDividerSelect == COLL_BANNED))
    else $error("banned code full table");
  AST_REDUCED_BANNED: assert property (
    red |-> collisionSelectBanned == cfg.collisionClockDividerSelect[1])
    else $error("banned code reduced table");
  AST_NO_TICK_BANNED: assert property (collisionSelectBanned [*2] |=> !collisionTick)
    else $error("collision tick on banned code");
  // Select must have been registered last cycle, else the reload drops the tick
  AST_DIV1_FOLLOW: assert property (
    !red && cfg.collisionClockDividerSelect == COLL_DIV1 && clkEn && $past(clkEn) &&
    $stable(cfg.collisionClockDividerSelect) |=> collisionTick == baseTick)
    else $error("undivided collision tick differs from base tick");
  AST_SMART_MASK: assert property (
    cfg.smartCardSelect |-> (status.flags & ~ST_SMART_MASK) == 9'h000)
    else $error("smart card flag mask");
  AST_FIFO_MASK: assert property (
    !cfg.smartCardSelect && cfg.fifoModeSelect |-> (status.flags & ~ST_FIFO_MASK) == 9'h000)
    else $error("fifo flag mask");
  AST_WORD_SPLIT: assert property (
    receiveWordCombined == {7'h00, receiveHigh[0], receiveLow} && receiveHigh[7:1] == 7'h00)
    else $error("combined word differs from parts");
  COV_COLL: cover property (collisionTick && !red);
  COV_SMART: cover property (cfg.smartCardSelect && status.flags[ST_RECEIVE_FULL]);
  COV_SYNC_EXT: cover property (cfg.syncMode && !serialClockOe);
endmodule : scf_serial_clock_format_asserts

bind scf_serial_clock_format scf_serial_clock_format_asserts u_chk (
  .clk(clk), .arst_n(arst_n), .clkEn(clkEn), .cfg(cfg), .serialClockOe(serialClockOe),
  .baseTick(baseTick), .collisionTick(collisionTick),
  .collisionSelectBanned(collisionSelectBanned), .charBits(charBits), .status(status),
  .receiveHigh(receiveHigh), .receiveLow(receiveLow),
  .receiveWordCombined(receiveWordCombined));

// [tb/testbench.sv]
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import scf_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, clkEn = 1'b1, run = 1'b0, rxDone = 1'b0, txTk = 1'b0;
  logic txAll = 1'b0, pe = 1'b0, fe = 1'b0, oe = 1'b0, rxLim = 1'b0, txLim = 1'b0;
  logic wrH = 1'b0, wrL = 1'b0, wrC = 1'b0, tmB = 1'b0, pinIn, sco, scoe, bt, bit_, ct, ban;
  logic [8:0] rxD = 9'h000, clr = 9'h000;
  logic [15:0] wd = 16'h0000, rw, tw;
  logic [7:0] rh, rl;
  logic [3:0] cb;
  scf_cfg_t cfg = '0;
  scf_status_t st;
  int n_mismatch = 0, num_checks = 0, nb, nt, nc, nsr;
  always #2.5 clk = !clk;
  scf_remote_dev u_dev (.clk(clk), .run(run), .serialClockIn(pinIn));
  scf_serial_clock_format DUT (.clk(clk), .arst_n(arst_n), .clkEn(clkEn), .cfg(cfg),
    .serialClockIn(pinIn), .timerMatchA(pinIn), .timerMatchB(tmB), .rxCharDone(rxDone),
    .rxCharData(rxD), .txCharTaken(txTk), .txAllDone(txAll), .parityErrEvent(pe),
    .framingErrEvent(fe), .overrunErrEvent(oe), .rxFifoAtLimit(rxLim),
    .txFifoAtLimit(txLim), .statusClear(clr), .txWriteHigh(wrH), .txWriteLow(wrL),
    .txWriteCombined(wrC), .txWriteData(wd), .serialClockOut(sco), .serialClockOe(scoe),
    .baseTick(bt), .bitTick(bit_), .collisionTick(ct), .collisionSelectBanned(ban),
    .charBits(cb), .status(st), .receiveHigh(rh), .receiveLow(rl),
    .receiveWordCombined(rw), .transmitWordCombined(tw));
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic check_val(input string nm, input logic [15:0] e, input logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : check_val
  task automatic check_near(input string nm, input int e, input int s, input int tol);
    num_checks++;
    if (s < e - tol || s > e + tol) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, s);
    end
  endtask : check_near
  // Counts over a window; a few cycles settle first so a select change is not counted
  task automatic count(input int n);
    logic ps;
    step(4);
    nb = 0; nt = 0; nc = 0; nsr = 0;
    ps = sco;
    repeat (n) begin
      step(1);
      nb += (bt === 1'b1); nt += (bit_ === 1'b1); nc += (ct === 1'b1);
      nsr += (sco === 1'b1 && ps === 1'b0);
      ps = sco;
    end
  endtask : count
  task automatic t_reset;
    cfg.fifoModeSelect = 1'b1;
    step(1);
    check_val("tx word", 16'h01FF, tw);
    check_val("fifo flags", 16'h0108, {7'h00, st.flags});
    cfg.smartCardSelect = 1'b1;
    step(1);
    check_val("smart flags", 16'h0002, {7'h00, st.flags});
    cfg = '0;
  endtask : t_reset
  task automatic t_pin;
    logic [3:0] tbl [6] = '{4'h0, 4'h3, 4'h4, 4'h6, 4'h9, 4'hC};
    foreach (tbl[i]) begin
      {cfg.syncMode, cfg.clockSelect[1], cfg.clockSelect[0]} = tbl[i][3:1];
      cfg.asyncClockSourceSelect = tbl[i][1] & !tbl[i][3];
      step(1);
      check_val("clock oe", {15'h0000, tbl[i][0]}, {15'h0000, scoe});
    end
    cfg = '0;
  endtask : t_pin
  task automatic t_char;
    for (int i = 0; i < 4; i++) begin
      {cfg.charLengthHigh, cfg.charLengthLow} = i[1:0];
      step(1);
      check_val("char bits", (i < 2) ? 16'h0009 : (i == 2 ? 16'h0008 : 16'h0007),
        {12'h000, cb});
    end
  endtask : t_char
  task automatic t_coll_codes;
    logic e;
    for (int i = 0; i < 12; i++) begin
      cfg.doubleSpeedSelect = (i >= 4);
      cfg.prescalerSelect = (i >= 8) ? 2'h1 : 2'h0;
      cfg.collisionClockDividerSelect = i[1:0];
      e = (i >= 4 && i < 8) ? i[1] : (i[1:0] == 2'h3);
      step(1);
      check_val("banned", {15'h0000, e}, {15'h0000, ban});
    end
    cfg = '0;
  endtask : t_coll_codes
  task automatic t_rates;
    cfg.collisionClockDividerSelect = COLL_DIV2;
    cfg.clockSelect = CKSEL_INT_OUT;
    count(160);
    check_near("base", 80, nb, 1);
    check_near("bit", 5, nt, 1);
    check_near("clock out rises", 5, nsr, 1);
    check_near("coll div2", 40, nc, 1);
    cfg.collisionClockDividerSelect = COLL_DIV4;
    count(160);
    check_near("coll div4", 20, nc, 1);
    cfg.doubleSpeedSelect = 1'b1;
    cfg.collisionClockDividerSelect = COLL_DIV1;
    count(160);
    check_near("double base", 160, nb, 1);
    check_near("reduced div2", 80, nc, 1);
    cfg = '0;
    cfg.bitRateSetting = 8'h03;
    count(160);
    check_near("rate 3", 20, nb, 1);
    cfg.bitRateSetting = 8'h00;
    cfg.rateModulationEnable = 1'b1;
    cfg.modulationDutySetting = 8'h80;
    count(160);
    check_near("modulated", 40, nb, 2);
    cfg = '0;
    step(1);
    // Freeze on a quiet cycle so the held tick is low
    if (bt === 1'b1) step(1);
    clkEn = 1'b0;
    count(40);
    check_near("frozen", 0, nb, 0);
    check_near("frozen coll", 0, nc, 0);
    clkEn = 1'b1;
  endtask : t_rates
  task automatic t_ext;
    cfg.clockSelect = 2'h2;
    run = 1'b1;
    count(320);
    check_near("ext base", 160, nb, 1);
    check_near("ext bit 16", 10, nt, 1);
    cfg.baseClockEighthSelect = 1'b1;
    count(320);
    check_near("ext bit 8", 20, nt, 1);
    cfg.asyncClockSourceSelect = 1'b1;
    tmB = 1'b1;
    count(160);
    check_near("timer base", 80, nb, 1);
    tmB = 1'b0;
    count(40);
    check_near("timer gated", 0, nb, 0);
    cfg = '0;
    cfg.syncMode = 1'b1;
    cfg.clockSelect = 2'h2;
    count(160);
    check_near("sync ext bit", 80, nt, 1);
    run = 1'b0;
    count(40);
    check_near("idle pin", 0, nt, 0);
    cfg = '0;
  endtask : t_ext
  task automatic t_status;
    cfg.fifoModeSelect = 1'b1;
    rxD = 9'h1A5;
    {rxDone, txTk, txAll, pe, fe, oe, rxLim, txLim} = 8'hFF;
    step(1);
    {rxDone, txTk, txAll, pe, fe, oe, rxLim, txLim} = 8'h00;
    check_val("fifo all", 16'h01FC, {7'h00, st.flags});
    check_val("rx word", 16'h01A5, rw);
    check_val("rx parts", 16'h01A5, {rh, rl});
    cfg.smartCardSelect = 1'b1;
    step(1);
    check_val("smart all", 16'h0003, {7'h00, st.flags});
    clr = 9'h1FF;
    step(1);
    clr = 9'h000;
    cfg.smartCardSelect = 1'b0;
    step(1);
    check_val("cleared", 16'h0000, {7'h00, st.flags});
    pe = 1'b1; clr = 9'h010;
    step(1);
    pe = 1'b0; clr = 9'h000;
    check_val("set wins", 16'h0010, {7'h00, st.flags});
    wrC = 1'b1; wd = 16'h0155;
    step(1);
    check_val("tx combined", 16'h0155, tw);
    wrC = 1'b0; wrL = 1'b1; wd = 16'h00AA;
    step(1);
    check_val("tx low", 16'h01AA, tw);
    wrL = 1'b0; wrH = 1'b1; wd = 16'h0000;
    step(1);
    wrH = 1'b0;
    check_val("tx high", 16'h00AA, tw);
    cfg = '0;
  endtask : t_status
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #200000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    cfg.charLengthHigh = 1'b1;
    step(10);
    arst_n = 1'b1;
    step(1);
    t_reset();
    t_pin();
    t_char();
    t_coll_codes();
    t_rates();
    t_ext();
    t_status();
    tally_and_finish();
  end
endmodule : testbench
